// [include/mit_pkg.sv]
// constants shared by the interrupt and timer core
package mit_pkg;
  // register addresses in the register space (page 1 for the counters)
  localparam logic [7:0] ADDR_FIRST_COUNTER_OVERFLOW_FLAG  = 8'h0C;
  localparam logic [7:0] ADDR_SECOND_COUNTER_OVERFLOW_FLAG  = 8'h0D;
  localparam logic [7:0] ADDR_PFLAG = 8'h0E;
  localparam logic [7:0] ADDR_ISTAT = 8'h0F;
  // mask register address in the control space
  localparam logic [7:0] ADDR_IMASK = 8'h0F;
  localparam logic [1:0] PAGE_0     = 2'h0;
  localparam logic [1:0] PAGE_1     = 2'h1;
  // peripheral flag and wake register fields
  localparam int PF_WAKE_EN = 0;
  localparam int PF_PWM_ONE_PERIOD_FLAG    = 4;
  localparam int PF_ADC     = 5;
  localparam int PF_SPI     = 6;
  localparam int PF_PWM_TWO_PERIOD_FLAG    = 7;
  localparam logic [7:0] PF_RW_MASK = 8'hF1;
  // interrupt status fields
  localparam int IS_TB    = 0;
  localparam int IS_FIRST_COUNTER_OVERFLOW_FLAG  = 1;
  localparam int IS_SECOND_COUNTER_OVERFLOW_FLAG  = 2;
  localparam int IS_PIN_A = 3;
  localparam int IS_PIN_B = 4;
  localparam int IS_PIN_C = 5;
  localparam int IS_PIN_D = 7;
  localparam logic [7:0] IS_RW_MASK = 8'hBF;
  // control register fields
  localparam int CC_PSR_LSB  = 0;
  localparam int CC_PAB      = 3;
  localparam int CC_CONTEXT_BACKUP_ENABLE    = 4;
  localparam int CC_TS       = 5;
  localparam int CC_GIE      = 6;
  localparam int CC_EDGE_SEL = 7;
  // reset values
  localparam logic [7:0] RST_CNT    = 8'h00;
  localparam logic [7:0] RST_PFLAG  = 8'h00;
  localparam logic [7:0] RST_ISTAT  = 8'h00;
  localparam logic [7:0] RST_IMASK  = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_RDATA  = 8'h00;
endpackage

// [include/mit_cnt_if.sv]
// link between the core and one auxiliary counter
`timescale 1ns/1ps
interface mit_cnt_if #(parameter int W = 8);
  logic         tick;
  logic         preset_we;
  logic [W-1:0] preset_data;
  logic [W-1:0] count;
  logic         overflow;
  modport core (output tick, output preset_we, output preset_data,
                input count, input overflow);
  modport cnt  (input tick, input preset_we, input preset_data,
                output count, output overflow);
endinterface

// [rtl/mit_aux_counter.sv]
// auxiliary 8-bit up-counter with prescaler, preset and reload
`timescale 1ns/1ps
module mit_aux_counter #(
  parameter int CNT_W = 8,
  parameter int PSC_W = 8
) (
  // clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // core side
  mit_cnt_if.cnt   bus
);
  logic [PSC_W-1:0] psc;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] preset;
  logic             ovf;

  // prescaler wrap advances the counter, counter wrap reloads it
  wire psc_wrap = bus.tick && (psc == {PSC_W{1'b1}});
  wire cnt_wrap = psc_wrap && (count == {CNT_W{1'b1}});

  assign bus.count    = count;
  assign bus.overflow = ovf;

  // write presets and restarts the prescaler so the first period is whole
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      psc    <= '0;
      count  <= '0;
      preset <= '0;
      ovf    <= 1'b0;
    end else if (ce_i) begin
      ovf <= cnt_wrap && !bus.preset_we;
      if (bus.preset_we) begin
        preset <= bus.preset_data;
        count  <= bus.preset_data;
        psc    <= '0;
      end else begin
        if (bus.tick) psc <= psc + 1'b1;
        if (cnt_wrap) count <= preset;
        else if (psc_wrap) count <= count + 1'b1;
      end
    end
  end

  a_ovf_reload: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && cnt_wrap && !bus.preset_we) |=> (ovf && count == $past(preset)))
    else $error("counter did not reload preset after overflow");
  a_preset_load: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && bus.preset_we) |=> (count == $past(bus.preset_data) && preset == count))
    else $error("counter write did not preset the count");
endmodule

// [rtl/mit_core.sv]
// interrupt flag, wake-up and timer core
//
// Functional notes
// - first counter: 8-bit up-counter, prescaled, write presets, read counts, reloads.
// - second counter behaves the same as the first.
// - flag bit 4 sets on first pwm period, held until software clears.
// - flag bit 7 sets on second pwm period, held until software clears.
// - flag bit 5 sets when an adc conversion completes.
// - flag bit 6 sets on rising edge of spi receive-full.
// - flag bit 0 enables port 8 pin 0 wake, resets to 0.
// - status bit 0 sets on time-base overflow; any 1 is pending.
// - status bit 1 sets on first counter overflow.
// - status bit 2 sets on second counter overflow.
// - status bit 3 sets on port 7 pin 0 selected edge.
// - status bit 4 sets on port 7 pin 1 falling edge.
// - status bit 5 sets on port 7 pin 2 falling edge; bit 6 unused.
// - status bit 7 sets on port 7 pin 3 falling edge.
// - separate readable, clearable mask register gates status flags.
// - prescale code picks time-base 1:2..1:256 or watchdog 1:1..1:128.
// - one prescaler serves time base or watchdog, never both.
// - backup bit set: context saved on entry, restored on return.
// - time-base source bit picks instruction clock or slow tick.
// - global enable cleared by disable or irq entry, set by enable or return.
// - edge select: 0 rising, 1 falling for port 7 pin 0.
// - port 8 pin 0 wake triggers on its falling edge.
`timescale 1ns/1ps
module mit_core (
  // clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // register-space access
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [1:0] reg_page_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  input  wire logic [7:0] wdata_i,
  // control-space access (mask register)
  input  wire logic       ioc_we_i,
  input  wire logic       ioc_re_i,
  // control register access
  input  wire logic       ctrl_we_i,
  input  wire logic       ctrl_re_i,
  output logic [7:0]      rdata_o,
  // instruction strobes from the cpu
  input  wire logic       disable_irq_instruction_i,
  input  wire logic       enable_irq_instruction_i,
  input  wire logic       return_from_irq_instruction_i,
  input  wire logic       irq_taken_i,
  // event sources
  input  wire logic       pwm_one_period_i,
  input  wire logic       pwm_two_period_i,
  input  wire logic       adc_done_i,
  input  wire logic       spi_rx_full_i,
  input  wire logic [3:0] port7_pins_i,
  input  wire logic       port8_pin0_i,
  // time bases
  input  wire logic       slow_tick_i,
  input  wire logic       first_counter_overflow_flag_tick_i,
  input  wire logic       second_counter_overflow_flag_tick_i,
  input  wire logic       wdt_enable_i,
  input  wire logic       wdt_clear_i,
  // results
  output logic            irq_o,
  output logic            wake_o,
  output logic            ctx_save_o,
  output logic            ctx_restore_o,
  output logic            wdt_timeout_o
);
  logic [7:0] pflag;
  logic [7:0] istat;
  logic [7:0] imask;
  logic [7:0] ctrl;
  logic [7:0] psc;
  logic [7:0] time_base_counter;
  logic [7:0] watchdog_counter;
  logic       spi_prev;
  logic [3:0] p7_prev;
  logic       p8_prev;

  mit_cnt_if #(.W(8)) c1_if ();
  mit_cnt_if #(.W(8)) c2_if ();

  // address decode
  wire sel_first_counter_overflow_flag  = (reg_addr_i == mit_pkg::ADDR_FIRST_COUNTER_OVERFLOW_FLAG) && (reg_page_i == mit_pkg::PAGE_1);
  wire sel_second_counter_overflow_flag  = (reg_addr_i == mit_pkg::ADDR_SECOND_COUNTER_OVERFLOW_FLAG) && (reg_page_i == mit_pkg::PAGE_1);
  wire sel_pflag = (reg_addr_i == mit_pkg::ADDR_PFLAG) && (reg_page_i == mit_pkg::PAGE_0);
  wire sel_istat = (reg_addr_i == mit_pkg::ADDR_ISTAT);
  wire sel_imask = (reg_addr_i == mit_pkg::ADDR_IMASK) && (reg_page_i == mit_pkg::PAGE_0);
  wire wr_pflag  = reg_we_i && sel_pflag;
  wire wr_istat  = reg_we_i && sel_istat;
  wire wr_imask  = ioc_we_i && sel_imask;

  // counters
  assign c1_if.tick        = first_counter_overflow_flag_tick_i;
  assign c1_if.preset_we   = reg_we_i && sel_first_counter_overflow_flag;
  assign c1_if.preset_data = wdata_i;
  assign c2_if.tick        = second_counter_overflow_flag_tick_i;
  assign c2_if.preset_we   = reg_we_i && sel_second_counter_overflow_flag;
  assign c2_if.preset_data = wdata_i;

  mit_aux_counter #(.CNT_W(8), .PSC_W(8)) u_first_counter_overflow_flag (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .bus       (c1_if)
  );
  mit_aux_counter #(.CNT_W(8), .PSC_W(8)) u_second_counter_overflow_flag (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .bus       (c2_if)
  );

  // control fields
  wire [2:0] psr       = ctrl[mit_pkg::CC_PSR_LSB +: 3];
  wire       prescale_assign       = ctrl[mit_pkg::CC_PAB];
  wire       context_backup_enable     = ctrl[mit_pkg::CC_CONTEXT_BACKUP_ENABLE];
  wire       ts        = ctrl[mit_pkg::CC_TS];
  wire       gie       = ctrl[mit_pkg::CC_GIE];
  wire       edge_sel  = ctrl[mit_pkg::CC_EDGE_SEL];

  // shared prescaler: source and terminal mask follow the assignment bit
  wire       tb_src    = ts ? slow_tick_i : 1'b1;
  wire       wdt_src   = slow_tick_i && wdt_enable_i;
  wire       psc_src   = prescale_assign ? wdt_src : tb_src;
  wire [7:0] tb_mask   = 8'(({1'b0, 8'h01} << psr) * 2 - 1);
  wire [7:0] wdt_mask  = 8'(({1'b0, 8'h01} << psr) - 1);
  wire [7:0] psc_mask  = prescale_assign ? wdt_mask : tb_mask;
  wire       psc_out   = psc_src && ((psc & psc_mask) == psc_mask);
  wire       tb_step   = prescale_assign ? tb_src : psc_out;
  wire       wdt_step  = prescale_assign ? psc_out : wdt_src;
  wire       tb_ovf    = tb_step && (time_base_counter == 8'hFF);
  wire       wdt_ovf   = wdt_step && (watchdog_counter == 8'hFF) && !wdt_clear_i;

  // edge detection on synchronous pins
  wire       spi_rise  = spi_rx_full_i && !spi_prev;
  wire       p70_rise  = port7_pins_i[0] && !p7_prev[0];
  wire       p70_fall  = !port7_pins_i[0] && p7_prev[0];
  wire [3:0] p7_fall   = ~port7_pins_i & p7_prev;
  wire       pin_a_evt = edge_sel ? p70_fall : p70_rise;
  wire       p8_fall   = !port8_pin0_i && p8_prev;

  // hardware set terms for both flag registers
  wire [7:0] pflag_set = {pwm_two_period_i, spi_rise, adc_done_i, pwm_one_period_i,
                          4'h0};
  wire [7:0] istat_set = {p7_fall[3], 1'b0, p7_fall[2], p7_fall[1], pin_a_evt,
                          c2_if.overflow, c1_if.overflow, tb_ovf};

  // set wins over a software clear in the same cycle
  wire [7:0] pflag_keep = wr_pflag ? (wdata_i & mit_pkg::PF_RW_MASK) : pflag;
  wire [7:0] istat_keep = wr_istat ? (wdata_i & mit_pkg::IS_RW_MASK) : istat;
  wire [7:0] next_pflag = pflag_keep | pflag_set;
  wire [7:0] next_istat = istat_keep | istat_set;

  // global enable: clears take precedence so a taken irq never re-enables
  wire       gie_clr    = disable_irq_instruction_i || irq_taken_i;
  wire       gie_set    = enable_irq_instruction_i || return_from_irq_instruction_i;
  wire       gie_wr     = ctrl_we_i ? wdata_i[mit_pkg::CC_GIE] : gie;
  wire       next_gie   = gie_clr ? 1'b0 : (gie_set ? 1'b1 : gie_wr);
  wire [7:0] ctrl_base  = ctrl_we_i ? wdata_i : ctrl;

  // request and wake terms
  wire [7:0] pending    = next_istat & imask;
  wire       next_irq   = next_gie && (|pending);
  wire       next_wake  = (p8_fall && pflag[mit_pkg::PF_WAKE_EN]) ||
                          (|(istat_set[7:3] & imask[7:3]));

  // read mux
  wire [7:0] next_rdata =
    (reg_re_i && sel_first_counter_overflow_flag)  ? c1_if.count :
    (reg_re_i && sel_second_counter_overflow_flag)  ? c2_if.count :
    (reg_re_i && sel_pflag) ? pflag :
    (reg_re_i && sel_istat) ? istat :
    (ioc_re_i && sel_imask) ? imask :
    ctrl_re_i               ? ctrl : 8'h00;

  // flag, mask and control registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pflag <= mit_pkg::RST_PFLAG;
      istat <= mit_pkg::RST_ISTAT;
      imask <= mit_pkg::RST_IMASK;
      ctrl  <= mit_pkg::RST_CTRL;
    end else if (ce_i) begin
      pflag <= next_pflag;
      istat <= next_istat;
      if (wr_imask) imask <= wdata_i & mit_pkg::IS_RW_MASK;
      ctrl  <= {ctrl_base[7], next_gie, ctrl_base[5:0]};
    end
  end

  // prescaler, time base and watchdog
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      psc               <= 8'h00;
      time_base_counter <= 8'h00;
      watchdog_counter  <= 8'h00;
    end else if (ce_i) begin
      if (psc_src) psc <= psc + 8'h01;
      if (tb_step) time_base_counter <= time_base_counter + 8'h01;
      if (wdt_clear_i || !wdt_enable_i) watchdog_counter <= 8'h00;
      else if (wdt_step) watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // edge history and registered outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spi_prev      <= 1'b0;
      p7_prev       <= 4'hF;
      p8_prev       <= 1'b1;
      rdata_o       <= mit_pkg::RST_RDATA;
      irq_o         <= 1'b0;
      wake_o        <= 1'b0;
      ctx_save_o    <= 1'b0;
      ctx_restore_o <= 1'b0;
      wdt_timeout_o <= 1'b0;
    end else if (ce_i) begin
      spi_prev      <= spi_rx_full_i;
      p7_prev       <= port7_pins_i;
      p8_prev       <= port8_pin0_i;
      rdata_o       <= next_rdata;
      irq_o         <= next_irq;
      wake_o        <= next_wake;
      ctx_save_o    <= irq_taken_i && context_backup_enable;
      ctx_restore_o <= return_from_irq_instruction_i && context_backup_enable;
      wdt_timeout_o <= wdt_ovf;
    end
  end

  // checks on the flag and enable logic
  a_adc_flag_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && adc_done_i) |=> pflag[mit_pkg::PF_ADC])
    else $error("adc completion did not set its flag");
  a_spi_edge_only: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && spi_rx_full_i && spi_prev && !wr_pflag && !pflag[mit_pkg::PF_SPI])
    |=> !pflag[mit_pkg::PF_SPI])
    else $error("spi flag set without a rising edge");
  a_pin_a_edge: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && !edge_sel && port7_pins_i[0] && !p7_prev[0]) |=> istat[mit_pkg::IS_PIN_A])
    else $error("rising edge on pin a not flagged");
  a_flag_latched: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && istat[mit_pkg::IS_FIRST_COUNTER_OVERFLOW_FLAG] && !wr_istat) |=> istat[mit_pkg::IS_FIRST_COUNTER_OVERFLOW_FLAG])
    else $error("status flag dropped without software write");
  a_gie_entry_clr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && irq_taken_i) |=> (!gie ##1 1'b1))
    else $error("global enable not cleared on irq entry");
  // a frozen cycle holds irq_o, so only judge edges that really updated it
  a_irq_gated: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (irq_o && $past(ce_i)) |-> $past(next_gie) && (|$past(pending)))
    else $error("irq raised while masked or disabled");
  a_wake_p8: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ce_i && pflag[mit_pkg::PF_WAKE_EN] && p8_prev && !port8_pin0_i) |=> wake_o)
    else $error("port 8 falling edge did not wake");
  a_ctx_backup: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ctx_save_o && $past(ce_i)) |-> $past(irq_taken_i) && $past(context_backup_enable))
    else $error("context save without backup enable");
endmodule

// [tb/mit_evt_model.sv]
// pwm, adc and spi event source model on the far side of the core
`timescale 1ns/1ps
module mit_evt_model (
  // clock
  input  wire logic       ref_clk_i,
  // bench requests: pwm one, pwm two, adc, spi
  input  wire logic [3:0] fire_i,
  // event lines into the core
  output logic            pwm_one_o,
  output logic            pwm_two_o,
  output logic            adc_done_o,
  output logic            spi_full_o
);
  logic [2:0] spi_hold;
  initial begin
    {pwm_one_o, pwm_two_o, adc_done_o, spi_full_o} = 4'h0;
    spi_hold = 3'h0;
  end
  // one-cycle pulses launched off the sampling edge
  always @(negedge ref_clk_i) begin
    pwm_one_o  <= fire_i[0];
    pwm_two_o  <= fire_i[1];
    adc_done_o <= fire_i[2];
    // receive-full stays up a while, so only its rising edge may count
    spi_hold   <= fire_i[3] ? 3'h4 : ((spi_hold != 3'h0) ? spi_hold - 3'h1 : 3'h0);
    spi_full_o <= fire_i[3] | (spi_hold > 3'h1);
  end
endmodule

// [tb/test_mcu_interrupt_timer_core.sv]
// self-checking bench for the interrupt and timer core
`timescale 1ns/1ps
module test_mcu_interrupt_timer_core;
  logic       ref_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] page = 2'h0;
  logic [2:0] we = 3'h0, re = 3'h0;   // register, mask, control
  logic [3:0] strobes = 4'h0;         // disable, enable, return, taken
  logic [3:0] fire = 4'h0, port7 = 4'hF;
  logic       port8 = 1'b1, tick1 = 1'b0, tick2 = 1'b0, seen;
  logic       ce = 1'b1, slow = 1'b0, wdt_en = 1'b0, wdto;
  logic       pwm_one_period_flag, pwm_two_period_flag, adc, spi, irq, wake, save, restore;
  int         mismatches = 0, n_compared = 0, cycles = 0;

  mit_core u_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .reg_addr_i(addr), .reg_page_i(page), .reg_we_i(we[0]), .reg_re_i(re[0]),
    .wdata_i(wdata), .ioc_we_i(we[1]), .ioc_re_i(re[1]), .ctrl_we_i(we[2]),
    .ctrl_re_i(re[2]), .rdata_o(rdata), .disable_irq_instruction_i(strobes[0]),
    .enable_irq_instruction_i(strobes[1]), .return_from_irq_instruction_i(strobes[2]),
    .irq_taken_i(strobes[3]), .pwm_one_period_i(pwm_one_period_flag), .pwm_two_period_i(pwm_two_period_flag),
    .adc_done_i(adc), .spi_rx_full_i(spi), .port7_pins_i(port7), .port8_pin0_i(port8),
    .slow_tick_i(slow), .first_counter_overflow_flag_tick_i(tick1), .second_counter_overflow_flag_tick_i(tick2), .wdt_enable_i(wdt_en),
    .wdt_clear_i(1'b0), .irq_o(irq), .wake_o(wake), .ctx_save_o(save),
    .ctx_restore_o(restore), .wdt_timeout_o(wdto));
  mit_evt_model u_evt (.ref_clk_i(ref_clk_i), .fire_i(fire), .pwm_one_o(pwm_one_period_flag),
    .pwm_two_o(pwm_two_period_flag), .adc_done_o(adc), .spi_full_o(spi));

  always #50 ref_clk_i = ~ref_clk_i;
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("counts: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  // kind 0 register space, 1 mask register, 2 control register
  task automatic wr(input int k, input logic [7:0] a, input logic [1:0] p, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr  <= a;
    page  <= p;
    wdata <= d;
    we    <= 3'h1 << k;
    @(negedge ref_clk_i);
    we    <= 3'h0;
  endtask
  // read data stands one cycle, so it is taken at the next falling edge
  task automatic rd(input int k, input logic [7:0] a, input logic [1:0] p, input logic [7:0] e);
    @(negedge ref_clk_i);
    addr <= a;
    page <= p;
    re   <= 3'h1 << k;
    @(negedge ref_clk_i);
    re   <= 3'h0;
    chk8(rdata, e, "read");
  endtask
  task automatic pulse(input logic [3:0] s);
    @(negedge ref_clk_i);
    strobes <= s;
    @(negedge ref_clk_i);
    strobes <= 4'h0;
  endtask
  task automatic pins(input logic [3:0] v);
    @(negedge ref_clk_i);
    port7 <= v;
    step(3);
  endtask
  task automatic clr_status();
    wr(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h00);
  endtask

  task automatic t_reset();
    rd(0, mit_pkg::ADDR_FIRST_COUNTER_OVERFLOW_FLAG, mit_pkg::PAGE_1, 8'h00);
    rd(0, mit_pkg::ADDR_SECOND_COUNTER_OVERFLOW_FLAG, mit_pkg::PAGE_1, 8'h00);
    rd(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h00);
    rd(1, mit_pkg::ADDR_IMASK, mit_pkg::PAGE_0, 8'h00);
    rd(2, 8'h00, mit_pkg::PAGE_0, 8'h00);
    wr(0, 8'h20, mit_pkg::PAGE_0, 8'h55);
    rd(0, 8'h20, mit_pkg::PAGE_0, 8'h00);
    // slow source with no ticks keeps the time base still for later tests
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h20);
    clr_status();
    $display("test reset finished");
  endtask

  task automatic t_pflag();
    int pos[4] = '{4, 7, 5, 6};
    wr(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'hF1);
    rd(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'hF1);
    wr(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk_i);
      fire <= 4'h1 << i;
      @(negedge ref_clk_i);
      fire <= 4'h0;
      step(8);
      rd(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h01 << pos[i]);
      wr(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
      rd(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
    end
    // clear while receive-full still stands: a level must not set it again
    @(negedge ref_clk_i);
    fire <= 4'h8;
    @(negedge ref_clk_i);
    fire <= 4'h0;
    wr(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
    step(6);
    rd(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, 8'h00);
    $display("test flag register finished");
  endtask

  task automatic t_pins();
    pins(4'h1);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'hB0);
    pins(4'hF);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_1, 8'hB0);
    clr_status();
    pins(4'hE);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h00);
    pins(4'hF);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h08);
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'hA0);
    clr_status();
    pins(4'hE);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h08);
    pins(4'hF);
    rd(2, 8'h00, mit_pkg::PAGE_0, 8'hA0);
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h30);
    clr_status();
    $display("test pin edges finished");
  endtask

  task automatic t_irq();
    wr(1, mit_pkg::ADDR_IMASK, mit_pkg::PAGE_0, 8'h10);
    rd(1, mit_pkg::ADDR_IMASK, mit_pkg::PAGE_0, 8'h10);
    pulse(4'h2);
    rd(2, 8'h00, mit_pkg::PAGE_0, 8'h70);
    pins(4'hD);
    chk1(irq, 1'b1, "irq");
    pulse(4'h8);
    chk1(save, 1'b1, "save");
    step(2);
    chk1(irq, 1'b0, "irq");
    rd(2, 8'h00, mit_pkg::PAGE_0, 8'h30);
    pulse(4'h4);
    chk1(restore, 1'b1, "restore");
    step(2);
    chk1(irq, 1'b1, "irq");
    wr(1, mit_pkg::ADDR_IMASK, mit_pkg::PAGE_0, 8'h00);
    step(2);
    chk1(irq, 1'b0, "irq");
    pulse(4'h1);
    rd(2, 8'h00, mit_pkg::PAGE_0, 8'h30);
    pins(4'hF);
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h20);
    $display("test interrupt request finished");
  endtask

  task automatic t_count(input int i);
    logic [7:0] a;
    a = i ? mit_pkg::ADDR_SECOND_COUNTER_OVERFLOW_FLAG : mit_pkg::ADDR_FIRST_COUNTER_OVERFLOW_FLAG;
    wr(0, a, mit_pkg::PAGE_1, 8'h5A);
    rd(0, a, mit_pkg::PAGE_1, 8'h5A);
    clr_status();
    wr(0, a, mit_pkg::PAGE_1, 8'hFF);
    for (int n = 0; n < 256; n++) begin
      if (n == 255) begin
        rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h00);
        rd(0, a, mit_pkg::PAGE_1, 8'hFF);
      end
      @(negedge ref_clk_i);
      {tick2, tick1} <= 2'h1 << i;
      @(negedge ref_clk_i);
      {tick2, tick1} <= 2'h0;
    end
    step(4);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h02 << i);
    rd(0, a, mit_pkg::PAGE_1, 8'hFF);
    clr_status();
    $display("test counter finished");
  endtask

  task automatic t_tbase();
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h28);
    clr_status();
    step(600);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h00);
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h08);
    step(260);
    rd(0, mit_pkg::ADDR_ISTAT, mit_pkg::PAGE_0, 8'h01);
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h20);
    clr_status();
    $display("test time base finished");
  endtask

  task automatic t_wdt();
    int n;
    // watchdog on the shared prescaler at 1:1, frozen for 10 cycles midway
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h08);
    n = 0;
    @(negedge ref_clk_i);
    slow   <= 1'b1;
    wdt_en <= 1'b1;
    while (n < 600 && wdto !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
      ce <= !(n >= 100 && n < 110);
    end
    chk1(n == 266, 1'b1, "watchdog 1:1 with freeze");
    wdt_en <= 1'b0;
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h09);
    n = 0;
    @(negedge ref_clk_i);
    wdt_en <= 1'b1;
    while (n < 600 && wdto !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
    end
    // prescaler phase is never reset, so the 1:2 period may end a step early
    chk1(n == 511 || n == 512, 1'b1, "watchdog 1:2");
    wdt_en <= 1'b0;
    slow   <= 1'b0;
    wr(2, 8'h00, mit_pkg::PAGE_0, 8'h20);
    clr_status();
    $display("test watchdog finished");
  endtask

  task automatic t_wake(input logic en);
    wr(0, mit_pkg::ADDR_PFLAG, mit_pkg::PAGE_0, {7'h00, en});
    seen = 1'b0;
    @(negedge ref_clk_i);
    port8 <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk_i);
      seen = seen | wake;
    end
    chk1(seen, en, "wake");
    port8 <= 1'b1;
    step(2);
    $display("test wake finished");
  endtask

  initial begin
    step(10);
    resetn_i <= 1'b1;
    t_reset();
    t_pflag();
    t_pins();
    t_irq();
    t_count(0);
    t_count(1);
    t_tbase();
    t_wdt();
    t_wake(1'b1);
    t_wake(1'b0);
    tally_and_finish();
  end
endmodule
